// ### design/xcvr_pkg.sv
`default_nettype none
package xcvr_pkg;
   // Scratch register offset above port base
   localparam logic [2:0] scratch_offset = 3'h7;
   localparam logic [7:0] mode_reset     = 8'h00;
   localparam int         mode_lsb       = 0;
   localparam int         mode_msb       = 1;

   typedef enum logic [1:0] {
      mode_four_wire = 2'h0,
      mode_echo      = 2'h1,
      mode_dtr_ctrl  = 2'h2,
      mode_auto      = 2'h3
   } xcvr_mode_e;

   // Host-side I/O access for one port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } io_req_s;

   // Line transceiver enables, active high
   typedef struct packed {
      logic drv_en;
      logic rcv_en;
   } xcvr_en_s;

   localparam logic [7:0] rdata_reset    = 8'h00;
   localparam logic [7:0] unmapped_rdata = 8'h00;
   // Synchroniser starts unasserted so no false assert follows reset
   localparam logic [2:0] sync_reset     = 3'h7;
   localparam logic       sync_q_reset   = 1'h1;
   localparam xcvr_en_s   en_reset       = '{drv_en: 1'h1, rcv_en: 1'h1};
endpackage
`default_nettype wire

// ### design/xcvr_sync.sv
`default_nettype none
// Three-stage synchroniser; change accepted when stages two and three agree
module xcvr_sync
(
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic d_in,
   output logic      q_out
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic       q_reg;
   logic       q_next;

   always_comb
   begin
      stage_next = {stage_reg[1:0], d_in};
      q_next     = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : q_reg;
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         stage_reg <= xcvr_pkg::sync_reset;
         q_reg     <= xcvr_pkg::sync_q_reset;
      end
      else
      begin
         stage_reg <= stage_next;
         q_reg     <= q_next;
      end
   end

   assign q_out = q_reg;
endmodule // xcvr_sync
`default_nettype wire

// ### design/rs485_direction_control.sv
`default_nettype none
module rs485_direction_control
(
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire xcvr_pkg::io_req_s io_req,
   output logic [7:0]            io_rdata,
   input  wire logic             dtr_n,
   input  wire logic             transmit_slot_ready_n,
   output xcvr_pkg::xcvr_en_s    xcvr_en,
   output xcvr_pkg::xcvr_mode_e  mode
);
   logic [7:0]           scratch_reg;
   logic [7:0]           scratch_next;
   logic [7:0]           rdata_reg;
   logic [7:0]           rdata_next;
   logic                 dtr_n_s;
   logic                 slot_ready_n_s;
   logic                 dtr_asserted;
   logic                 slot_ready_asserted;
   xcvr_pkg::xcvr_mode_e mode_now;
   xcvr_pkg::xcvr_en_s   en_next;
   xcvr_pkg::xcvr_en_s   en_reg;

   function automatic logic hit(input xcvr_pkg::io_req_s r);
      hit = (r.addr == xcvr_pkg::scratch_offset);
   endfunction

   // Pins arrive from the UART clock domain side
   xcvr_sync u_dtr
   (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .d_in     (dtr_n),
      .q_out    (dtr_n_s)
   );
   xcvr_sync u_slot_ready
   (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .d_in     (transmit_slot_ready_n),
      .q_out    (slot_ready_n_s)
   );

   assign dtr_asserted        = ~dtr_n_s;
   assign slot_ready_asserted = ~slot_ready_n_s;

   always_comb
   begin
      scratch_next = scratch_reg;
      rdata_next   = rdata_reg;
      if (io_req.wr && hit(io_req))
      begin
         scratch_next = io_req.wdata;
      end
      if (io_req.rd)
      begin
         rdata_next = hit(io_req) ? scratch_reg : xcvr_pkg::unmapped_rdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         scratch_reg <= xcvr_pkg::mode_reset;
         rdata_reg   <= xcvr_pkg::rdata_reset;
      end
      else
      begin
         scratch_reg <= scratch_next;
         rdata_reg   <= rdata_next;
      end
   end

   scratch_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      io_req.wr && hit(io_req) |=> scratch_reg == $past(io_req.wdata))
      else $error("scratch write lost");
   write_miss_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      io_req.wr && !hit(io_req) |=> $stable(scratch_reg))
      else $error("scratch written from other offset");
   read_hit_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      io_req.rd && hit(io_req) |=> io_rdata == $past(scratch_reg))
      else $error("scratch read wrong");
   read_miss_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      io_req.rd && !hit(io_req) |=> io_rdata == xcvr_pkg::unmapped_rdata)
      else $error("unmapped read not empty");
   rdata_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      !io_req.rd |=> $stable(io_rdata))
      else $error("read data changed without read");

   // only the low two bits matter; codes map directly
   // mode taken straight from the register, no extra stage
   assign mode_now = xcvr_pkg::xcvr_mode_e'(scratch_reg[xcvr_pkg::mode_msb:xcvr_pkg::mode_lsb]);

   always_comb
   begin
      en_next = '{drv_en: 1'h1, rcv_en: 1'h1};
      unique case (mode_now)
         xcvr_pkg::mode_four_wire:
         begin
            en_next = '{drv_en: 1'h1, rcv_en: 1'h1};
         end
         xcvr_pkg::mode_echo:
         begin
            en_next = '{drv_en: ~dtr_asserted, rcv_en: 1'h1};
         end
         xcvr_pkg::mode_dtr_ctrl:
         begin
            en_next = '{drv_en: ~dtr_asserted, rcv_en: dtr_asserted};
         end
         // per-byte driving; host keeps FIFOs on
         xcvr_pkg::mode_auto:
         begin
            en_next = '{drv_en: slot_ready_asserted, rcv_en: ~slot_ready_asserted};
         end
      endcase
   end

   // Registered so enables never glitch onto the line
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         en_reg <= xcvr_pkg::en_reset;
      end
      else
      begin
         en_reg <= en_next;
      end
   end

   assign xcvr_en  = en_reg;
   assign mode     = mode_now;
   assign io_rdata = rdata_reg;

   four_wire_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(mode_now) == xcvr_pkg::mode_four_wire |-> xcvr_en.drv_en && xcvr_en.rcv_en)
      else $error("four-wire enables dropped");
   echo_drv_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(mode_now) == xcvr_pkg::mode_echo |-> xcvr_en.drv_en == $past(dtr_n_s))
      else $error("echo driver wrong");
   echo_rcv_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(mode_now) == xcvr_pkg::mode_echo |-> xcvr_en.rcv_en)
      else $error("echo receiver off");
   dtr_excl_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(mode_now) == xcvr_pkg::mode_dtr_ctrl |-> xcvr_en.rcv_en != xcvr_en.drv_en)
      else $error("dtr mode enables overlap");
   dtr_drv_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(mode_now) == xcvr_pkg::mode_dtr_ctrl |-> xcvr_en.drv_en == $past(dtr_n_s))
      else $error("dtr mode driver wrong");
   auto_drv_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(mode_now) == xcvr_pkg::mode_auto |-> xcvr_en.drv_en == !$past(slot_ready_n_s))
      else $error("auto driver wrong");
   auto_rcv_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(mode_now) == xcvr_pkg::mode_auto |-> xcvr_en.rcv_en == $past(slot_ready_n_s))
      else $error("auto receiver wrong");
   auto_excl_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(mode_now) == xcvr_pkg::mode_auto |-> xcvr_en.rcv_en != xcvr_en.drv_en)
      else $error("auto mode enables overlap");
   dtr_rcv_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $past(mode_now) == xcvr_pkg::mode_dtr_ctrl |-> xcvr_en.rcv_en == !$past(dtr_n_s))
      else $error("dtr mode receiver wrong");
   mode_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      io_req.wr && io_req.addr == xcvr_pkg::scratch_offset
      |=> mode == xcvr_pkg::xcvr_mode_e'($past(io_req.wdata[1:0])))
      else $error("mode write not applied");
   mode_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      !(io_req.wr && hit(io_req)) |=> $stable(mode))
      else $error("mode changed without write");
   four_wire_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      io_req.wr && hit(io_req)
      && xcvr_pkg::xcvr_mode_e'(io_req.wdata[1:0]) == xcvr_pkg::mode_four_wire
      |=> ##1 xcvr_en.drv_en && xcvr_en.rcv_en)
      else $error("four-wire write not applied to enables");
endmodule // rs485_direction_control
`default_nettype wire

// ### testbench/uart_pin_model.sv
`default_nettype none
module uart_pin_model
(
   input  wire logic clk_sys,
   input  wire logic send,
   output logic      dtr_n,
   output logic      transmit_slot_ready_n
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial dtr_n = 1'b0;
   initial transmit_slot_ready_n = 1'b1;
   always @(posedge clk_sys)
   begin
      cnt <= send ? 20 : (cnt > 0 ? cnt - 1 : 0);
      // bit cleared first, set after last slot
      dtr_n <= send || cnt > 1;
      // slots only come from an enabled FIFO
      transmit_slot_ready_n <= !(cnt > 6 && cnt < 19);
   end
endmodule // uart_pin_model
`default_nettype wire

// ### testbench/rs485_direction_control_tb.sv
`default_nettype none
module rs485_direction_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk_sys = 1'b0;
   logic                 nrst = 1'b0;
   logic                 send = 1'b0;
   logic                 dtr_n;
   logic                 tsr_n;
   logic [7:0]           io_rdata;
   xcvr_pkg::io_req_s    io_req = '0;
   xcvr_pkg::xcvr_en_s   xcvr_en;
   xcvr_pkg::xcvr_mode_e mode;
   xcvr_pkg::io_req_s    io_req_b = '0;
   xcvr_pkg::xcvr_en_s   xcvr_en_b;
   xcvr_pkg::xcvr_mode_e mode_b;
   int                   miscompares = 0;
   int                   checked = 0;
   int                   cycles = 0;
   always #25 clk_sys = ~clk_sys;
   rs485_direction_control dut
   (.clk_sys(clk_sys), .nrst(nrst), .io_req(io_req), .io_rdata(io_rdata),
    .dtr_n(dtr_n), .transmit_slot_ready_n(tsr_n), .xcvr_en(xcvr_en), .mode(mode));
   uart_pin_model peer
   (.clk_sys(clk_sys), .send(send), .dtr_n(dtr_n), .transmit_slot_ready_n(tsr_n));
   // Second port shares the pins but keeps its own mode
   rs485_direction_control port_b
   (.clk_sys(clk_sys), .nrst(nrst), .io_req(io_req_b), .io_rdata(),
    .dtr_n(dtr_n), .transmit_slot_ready_n(tsr_n), .xcvr_en(xcvr_en_b), .mode(mode_b));
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic settle(int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic access(logic wr, logic [2:0] a, logic [7:0] d);
      @(posedge clk_sys);
      io_req <= {wr, !wr, a, d};
      @(posedge clk_sys);
      io_req <= '0;
   endtask
   // Enables as {drv, rcv}; terminal-ready and slot-ready are active low
   function automatic logic [1:0] want(logic [1:0] m, logic d_n, logic t_n);
      case (m)
         2'h0: want = 2'b11;
         2'h1: want = {d_n, 1'b1};
         2'h2: want = {d_n, !d_n};
         default: want = {!t_n, t_n};
      endcase
   endfunction
   task automatic t_reset;
      check("mode", 8'h00, {6'h0, mode});
      check("xcvr_en", 8'h03, {6'h0, xcvr_en});
      access(1'b0, 3'h7, 8'h00);
      settle(1);
      check("scratch", 8'h00, io_rdata);
   endtask
   task automatic t_decode;
      access(1'b1, 3'h7, 8'hfd);
      settle(1);
      check("mode", 8'h01, {6'h0, mode});
      access(1'b0, 3'h7, 8'h00);
      settle(1);
      check("scratch", 8'hfd, io_rdata);
      access(1'b1, 3'h3, 8'h02);
      access(1'b0, 3'h3, 8'h00);
      settle(1);
      check("offset 3", 8'h00, io_rdata);
      check("mode", 8'h01, {6'h0, mode});
   endtask
   // Each mode: idle enables, then enables in mid-byte
   task automatic t_modes;
      for (int m = 0; m < 4; m++)
      begin
         access(1'b1, 3'h7, 8'(m));
         settle(1);
         check("mode", 8'(m), {6'h0, mode});
         settle(1);
         check("idle en", {6'h0, want(2'(m), 1'b0, 1'b1)}, {6'h0, xcvr_en});
         @(posedge clk_sys);
         send <= 1'b1;
         @(posedge clk_sys);
         send <= 1'b0;
         settle(11);
         check("busy en", {6'h0, want(2'(m), 1'b1, 1'b0)}, {6'h0, xcvr_en});
         settle(24);
      end
   endtask
   task automatic t_ports;
      @(posedge clk_sys);
      io_req_b <= {1'b1, 1'b0, 3'h7, 8'h03};
      @(posedge clk_sys);
      io_req_b <= '0;
      settle(1);
      check("port b mode", 8'h03, {6'h0, mode_b});
      check("port b en", {6'h0, want(2'h3, 1'b0, 1'b1)}, {6'h0, xcvr_en_b});
      check("port a mode", 8'h01, {6'h0, mode});
   endtask
   // Reset after a non-default mode must clear the whole byte
   task automatic t_rereset;
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      settle(1);
      check("mode", 8'h00, {6'h0, mode});
      check("xcvr_en", 8'h03, {6'h0, xcvr_en});
      access(1'b0, 3'h7, 8'h00);
      settle(1);
      check("scratch", 8'h00, io_rdata);
   endtask
   task automatic summarize;
      if (miscompares == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         miscompares++;
         summarize();
      end
   end
   initial
   begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      settle(1);
      t_reset();
      t_decode();
      t_ports();
      t_modes();
      t_rereset();
      summarize();
   end
endmodule // rs485_direction_control_tb
`default_nettype wire
